// *** src/tic_defs.svh ***
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

// Register addresses in the special function space
`define TIC_ADDR_CTRL 8'ha1
`define TIC_ADDR_FRAC 8'ha2
`define TIC_ADDR_SEC 8'ha3
`define TIC_ADDR_MIN 8'ha4
`define TIC_ADDR_HOUR 8'ha5
`define TIC_ADDR_TARGET 8'ha6

// Control bit positions
`define TIC_BIT_TIMEBASE_CLOCK_ENABLE 0
`define TIC_BIT_INTERVAL_ENABLE 1
`define TIC_BIT_FLAG 2
`define TIC_BIT_SSHOT 3
`define TIC_BIT_TBSEL_LO 4
`define TIC_BIT_TBSEL_HI 5

// Counter limits and reset value
`define TIC_FRAC_MAX 8'h7f
`define TIC_SEC_MAX 8'h3b
`define TIC_MIN_MAX 8'h3b
`define TIC_HOUR_MAX 8'h17
`define TIC_ZERO 8'h00
`define TIC_ONE 8'h01
`define TIC_WAKE_VECTOR 16'h0053

// Timing: system clock rate and time-of-day tick rate
`define TIC_CLK_HZ 10000000
`define TIC_TICK_HZ 128
`define TIC_TICK_CYCLES (`TIC_CLK_HZ / `TIC_TICK_HZ)

`endif

// *** src/tic_pkg.sv ***
package tic_pkg;

    // Register access request from the core
    typedef struct packed {
        logic [7:0] addr;  // Register address
        logic wr;          // Write strobe
        logic rd;          // Read strobe
        logic [7:0] wdata; // Write data
    } tic_sfr_req_type;

    // Register access answer
    typedef struct packed {
        logic [7:0] rdata; // Read data, one cycle after rd
    } tic_sfr_rsp_type;

    // Interval timebase choices, in select field order
    typedef enum logic [1:0] {
        TB_FRAC,
        TB_SEC,
        TB_MIN,
        TB_HOUR
    } tic_tbase_type;

    // Control register fields
    typedef struct packed {
        logic [1:0] tbsel;      // Timebase select
        logic single_shot;      // Stop after one timeout
        logic interval_flag;    // Sticky match flag
        logic interval_enable;  // Interval counter runs
        logic timebase_clock_enable; // Time counters run
    } tic_ctrl_type;

    // Whole state of the top block
    typedef struct packed {
        tic_ctrl_type ctrl;  // Control fields
        logic [7:0] frac;    // 1/128 second count
        logic [7:0] sec;     // Seconds
        logic [7:0] min;     // Minutes
        logic [7:0] hour;    // Hours
        logic [7:0] target;  // Interval target
        logic [7:0] count;   // Interval counter
        logic [7:0] rdata;   // Read data register
    } tic_state_type;

endpackage

// *** src/tic_tick_div.sv ***
`timescale 1ns/1ps
`include "tic_defs.svh"

// Divides the system clock down to a one-cycle tick enable
module tic_tick_div #(
    parameter int CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic clk,  // System clock
    input wire logic rst,  // Synchronous reset, high
    output logic tick      // One-cycle pulse per period
);
    import tic_pkg::*;

    localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    // Divider state
    typedef struct packed {
        logic [W-1:0] cnt; // Cycles into the period
        logic tick;        // Registered tick
    } tic_div_type;

    tic_div_type div_ff;
    tic_div_type nxt_div;

    // Count to the end of the period, then pulse
    always_comb begin
        nxt_div = div_ff;
        nxt_div.tick = 1'b0;
        if (div_ff.cnt == LAST) begin
            nxt_div.cnt = '0;
            nxt_div.tick = 1'b1;
        end else begin
            nxt_div.cnt = div_ff.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick = div_ff.tick;

endmodule

// *** src/tic_top.sv ***
`timescale 1ns/1ps
`include "tic_defs.svh"

// Time interval counter with time-of-day registers
module tic_top #(
    parameter int TICK_CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic clk,                    // System clock, 10 MHz
    input wire logic rst,                    // Synchronous reset, high
    input wire tic_pkg::tic_sfr_req_type sfr_req, // Register request
    output tic_pkg::tic_sfr_rsp_type sfr_rsp,     // Register read data
    input wire logic int_enable,             // Interval interrupt enable
    input wire logic power_down,             // Core is powered down
    output logic irq,                        // Interrupt request
    output logic wake,                       // Wake request to core
    output logic [15:0] wake_vector          // Vector to start from
);
    import tic_pkg::*;

    tic_state_type st_ff;   // Registered state
    tic_state_type nxt_st;  // Next state
    logic tick128;          // 1/128 second enable
    logic tick;             // Tick passed by clock enable
    logic c_frac;           // Fraction rollover
    logic c_sec;            // Seconds rollover
    logic c_min;            // Minutes rollover
    logic c_hour;           // Hours rollover
    logic adv;              // Interval counter step
    logic hit;              // Counter reaches target
    logic [7:0] cnt_inc;    // Counter plus one
    logic ctrl_wr;          // Control register write
    logic time_wr_ok;       // Time registers may be written

    // Tick from the always-on clock; shares clk here, one domain only
    tic_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .tick(tick128)
    );

    // Carry chain and interval step, from current state
    always_comb begin
        tick = tick128 & st_ff.ctrl.timebase_clock_enable;
        c_frac = tick & (st_ff.frac == `TIC_FRAC_MAX);
        c_sec = c_frac & (st_ff.sec == `TIC_SEC_MAX);
        c_min = c_sec & (st_ff.min == `TIC_MIN_MAX);
        c_hour = c_min & (st_ff.hour == `TIC_HOUR_MAX);
        // Rate picks the tick or the rollover that clocks the interval counter
        unique case (tic_tbase_type'(st_ff.ctrl.tbsel))
            TB_FRAC: adv = tick;
            TB_SEC: adv = c_frac;
            TB_MIN: adv = c_sec;
            TB_HOUR: adv = c_min;
        endcase
        adv = adv & st_ff.ctrl.interval_enable;
        cnt_inc = st_ff.count + `TIC_ONE;
        // Target zero matches after a full 256 steps
        hit = adv & (cnt_inc == st_ff.target);
        ctrl_wr = sfr_req.wr & (sfr_req.addr == `TIC_ADDR_CTRL);
        time_wr_ok = sfr_req.wr & ~st_ff.ctrl.timebase_clock_enable;
    end

    // Next state: counters, then register writes, then hardware events
    always_comb begin
        nxt_st = st_ff;
        // Time-of-day counters
        if (tick) begin
            nxt_st.frac = c_frac ? `TIC_ZERO : st_ff.frac + `TIC_ONE;
        end
        if (c_frac) begin
            nxt_st.sec = c_sec ? `TIC_ZERO : st_ff.sec + `TIC_ONE;
        end
        if (c_sec) begin
            nxt_st.min = c_min ? `TIC_ZERO : st_ff.min + `TIC_ONE;
        end
        if (c_min) begin
            nxt_st.hour = c_hour ? `TIC_ZERO : st_ff.hour + `TIC_ONE;
        end
        // Interval counter step, reload to zero at a match
        if (adv) begin
            nxt_st.count = hit ? `TIC_ZERO : cnt_inc;
        end
        // Register writes
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                `TIC_ADDR_CTRL: begin
                    // Reserved bits 7:6 are not stored and read zero
                    nxt_st.ctrl.tbsel = sfr_req.wdata[`TIC_BIT_TBSEL_HI:`TIC_BIT_TBSEL_LO];
                    nxt_st.ctrl.single_shot = sfr_req.wdata[`TIC_BIT_SSHOT];
                    nxt_st.ctrl.interval_flag = sfr_req.wdata[`TIC_BIT_FLAG];
                    nxt_st.ctrl.interval_enable = sfr_req.wdata[`TIC_BIT_INTERVAL_ENABLE];
                    nxt_st.ctrl.timebase_clock_enable = sfr_req.wdata[`TIC_BIT_TIMEBASE_CLOCK_ENABLE];
                    // Turning the time clock off clears the time registers
                    if (st_ff.ctrl.timebase_clock_enable && !sfr_req.wdata[`TIC_BIT_TIMEBASE_CLOCK_ENABLE]) begin
                        nxt_st.frac = `TIC_ZERO;
                        nxt_st.sec = `TIC_ZERO;
                        nxt_st.min = `TIC_ZERO;
                        nxt_st.hour = `TIC_ZERO;
                    end
                end
                `TIC_ADDR_FRAC: begin
                    if (time_wr_ok) begin
                        nxt_st.frac = sfr_req.wdata;
                    end
                end
                `TIC_ADDR_SEC: begin
                    if (time_wr_ok) begin
                        nxt_st.sec = sfr_req.wdata;
                    end
                end
                `TIC_ADDR_MIN: begin
                    if (time_wr_ok) begin
                        nxt_st.min = sfr_req.wdata;
                    end
                end
                `TIC_ADDR_HOUR: begin
                    if (time_wr_ok) begin
                        nxt_st.hour = sfr_req.wdata;
                    end
                end
                `TIC_ADDR_TARGET: begin
                    nxt_st.target = sfr_req.wdata;
                end
                default: begin
                    // Other addresses belong to other blocks
                end
            endcase
        end
        // Match sets the flag after the write, so the set wins
        if (hit) begin
            nxt_st.ctrl.interval_flag = 1'b1;
            if (st_ff.ctrl.single_shot) begin
                nxt_st.ctrl.interval_enable = 1'b0;
            end
        end
        // Disabled counter is held at zero
        if (!nxt_st.ctrl.interval_enable) begin
            nxt_st.count = `TIC_ZERO;
        end
        // Read data register
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                `TIC_ADDR_CTRL: nxt_st.rdata = {2'b00, st_ff.ctrl};
                `TIC_ADDR_FRAC: nxt_st.rdata = st_ff.frac;
                `TIC_ADDR_SEC: nxt_st.rdata = st_ff.sec;
                `TIC_ADDR_MIN: nxt_st.rdata = st_ff.min;
                `TIC_ADDR_HOUR: nxt_st.rdata = st_ff.hour;
                `TIC_ADDR_TARGET: nxt_st.rdata = st_ff.target;
                default: nxt_st.rdata = `TIC_ZERO;
            endcase
        end
    end

    // State register, all zero after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs; the interrupt gate lives in the core's enable
    assign sfr_rsp.rdata = st_ff.rdata;
    assign irq = st_ff.ctrl.interval_flag & int_enable;
    assign wake = st_ff.ctrl.interval_flag & int_enable & power_down;
    assign wake_vector = `TIC_WAKE_VECTOR;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Single-shot timeout with no write in the way
    sequence s_hit_single;
        hit && st_ff.ctrl.single_shot && !ctrl_wr;
    endsequence

    // Auto-reload timeout with no write in the way
    sequence s_hit_reload;
        hit && !st_ff.ctrl.single_shot && !ctrl_wr;
    endsequence

    a_flag_set: assert property (hit |=> st_ff.ctrl.interval_flag)
        else $error("flag not set on match");
    a_flag_sticky: assert property (st_ff.ctrl.interval_flag && !ctrl_wr
        |=> st_ff.ctrl.interval_flag)
        else $error("flag dropped without a write");
    a_single_stop: assert property (s_hit_single
        |=> !st_ff.ctrl.interval_enable && st_ff.count == `TIC_ZERO)
        else $error("single shot did not stop");
    a_reload_run: assert property (s_hit_reload
        |=> st_ff.ctrl.interval_enable && st_ff.count == `TIC_ZERO)
        else $error("reload did not restart");
    a_off_zero: assert property (!st_ff.ctrl.interval_enable
        |-> st_ff.count == `TIC_ZERO)
        else $error("disabled counter not zero");
    a_irq_gate: assert property (irq |-> int_enable && st_ff.ctrl.interval_flag)
        else $error("interrupt without enabled flag");
    // A rising request needs a match or a write one cycle earlier
    a_irq_cause: assert property ($rose(irq) && $stable(int_enable)
        |-> $past(hit) || $past(ctrl_wr))
        else $error("interrupt rose with no cause");
    a_frac_wrap: assert property (tick && st_ff.frac == `TIC_FRAC_MAX && !sfr_req.wr
        |=> st_ff.frac == `TIC_ZERO && st_ff.sec != $past(st_ff.sec))
        else $error("fraction wrap wrong");
    a_day_wrap: assert property (c_hour && !sfr_req.wr
        |=> st_ff.hour == `TIC_ZERO && st_ff.min == `TIC_ZERO && st_ff.sec == `TIC_ZERO)
        else $error("day wrap wrong");
    a_time_hold: assert property (!st_ff.ctrl.timebase_clock_enable && !sfr_req.wr
        |=> $stable(st_ff.frac) && $stable(st_ff.hour))
        else $error("time moved while clock off");
    // Switching the time clock off wipes the whole time of day
    a_clear_time: assert property (ctrl_wr && st_ff.ctrl.timebase_clock_enable
        && !sfr_req.wdata[`TIC_BIT_TIMEBASE_CLOCK_ENABLE]
        |=> st_ff.frac == `TIC_ZERO && st_ff.sec == `TIC_ZERO
        && st_ff.min == `TIC_ZERO && st_ff.hour == `TIC_ZERO)
        else $error("time not cleared on clock off");
    // Preload while stopped must land unchanged
    a_preload_frac: assert property (sfr_req.wr && sfr_req.addr == `TIC_ADDR_FRAC
        && !st_ff.ctrl.timebase_clock_enable
        |=> st_ff.frac == $past(sfr_req.wdata))
        else $error("fraction preload lost");
    a_wake_pd: assert property (power_down && int_enable && st_ff.ctrl.interval_flag
        |-> wake && wake_vector == `TIC_WAKE_VECTOR)
        else $error("no wake in power down");
    a_step_rate: assert property (adv && !hit && !ctrl_wr
        |=> st_ff.count == $past(cnt_inc))
        else $error("interval step lost");

endmodule

// *** test/time_interval_counter_tb_top.sv ***
`timescale 1ns/1ps
`include "tic_defs.svh"

// Self-checking bench for the time interval counter
module time_interval_counter_tb_top;
    import tic_pkg::*;
    localparam int TK = 4; // Short tick period keeps the run brief
    logic clk; // System clock
    logic rst; // Synchronous reset
    logic int_enable; // Interrupt enable level
    logic power_down; // Core asleep level
    logic irq; // Interrupt request
    logic wake; // Wake request
    logic [15:0] wake_vector; // Wake start address
    tic_sfr_req_type sfr_req; // Register request
    tic_sfr_rsp_type sfr_rsp; // Register answer
    int bad_count; // Mismatches seen
    int n_tests; // Comparisons made
    logic [7:0] rd_val; // Last read result
    int t; // Cycle count of a wait

    tic_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst(rst), .sfr_req(sfr_req),
        .sfr_rsp(sfr_rsp), .int_enable(int_enable), .power_down(power_down), .irq(irq),
        .wake(wake), .wake_vector(wake_vector));

    // Free-running clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // One comparison; four-state equality so unknowns fail
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Register write, strobe held for exactly one edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
    endtask

    // Register read; data lands on the edge that takes the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        #1 rd_val = sfr_rsp.rdata;
    endtask

    // Bounded wait for the interrupt line, counting falling edges
    // First look is at a falling edge: at the calling edge irq still shows old state
    task automatic wait_irq(input int n);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (irq !== 1'b1 && t < n);
    endtask

    // Power-on values, unmapped address included
    task automatic test_reset();
        for (int a = 'ha1; a <= 'ha7; a++) begin
            rd_reg(a[7:0]);
            check(rd_val, 8'h00, "reset value");
        end
        check(irq, 1'b0, "irq idle");
        check(wake_vector, `TIC_WAKE_VECTOR, "wake vector");
        $display("test reset done");
    endtask

    // Preload near all limits, then watch the whole carry chain wrap
    task automatic test_time();
        wr_reg(`TIC_ADDR_CTRL, 8'h40);
        wr_reg(`TIC_ADDR_FRAC, 8'h7e);
        wr_reg(`TIC_ADDR_SEC, 8'h3b);
        wr_reg(`TIC_ADDR_MIN, 8'h3b);
        wr_reg(`TIC_ADDR_HOUR, 8'h17);
        rd_reg(`TIC_ADDR_HOUR);
        check(rd_val, 8'h17, "preload hour");
        wr_reg(`TIC_ADDR_CTRL, 8'h41);
        rd_val = 8'hff;
        for (int i = 0; i < 20 && rd_val !== 8'h00; i++) rd_reg(`TIC_ADDR_FRAC);
        check(rd_val, 8'h00, "fraction wrap");
        rd_reg(`TIC_ADDR_SEC);
        check(rd_val, 8'h00, "seconds wrap");
        rd_reg(`TIC_ADDR_MIN);
        check(rd_val, 8'h00, "minutes wrap");
        rd_reg(`TIC_ADDR_HOUR);
        check(rd_val, 8'h00, "hours wrap");
        // Writes while running must be ignored
        wr_reg(`TIC_ADDR_SEC, 8'h05);
        rd_reg(`TIC_ADDR_SEC);
        check(rd_val, 8'h00, "running write");
        repeat (3 * TK) @(posedge clk);
        wr_reg(`TIC_ADDR_CTRL, 8'h40);
        repeat (3 * TK) @(posedge clk);
        rd_reg(`TIC_ADDR_FRAC);
        check(rd_val, 8'h00, "cleared and gated");
        $display("test time done");
    endtask

    // Each timebase: only its own rollover may fire the one-step interval
    task automatic test_rates();
        logic [1:0] tb;
        for (int i = 0; i < 4; i++) begin
            tb = i[1:0];
            wr_reg(`TIC_ADDR_CTRL, 8'h40);
            wr_reg(`TIC_ADDR_FRAC, 8'h7c);
            wr_reg(`TIC_ADDR_SEC, (i >= 2) ? 8'h3b : 8'h00);
            wr_reg(`TIC_ADDR_MIN, (i == 3) ? 8'h3b : 8'h00);
            wr_reg(`TIC_ADDR_TARGET, 8'h01);
            wr_reg(`TIC_ADDR_CTRL, {2'b01, tb, 4'b1011});
            wait_irq(6 * TK);
            if (i == 0) check(t <= TK + 2, 1'b1, "tick rate");
            else check(t > 3 * TK && t <= 4 * TK + 3, 1'b1, "rollover rate");
            rd_reg(`TIC_ADDR_CTRL);
            check(rd_val, {2'b00, tb, 4'b1101}, "single shot");
            @(posedge clk);
            power_down <= 1'b1;
            @(negedge clk);
            check(wake, 1'b1, "wake on flag");
            @(posedge clk);
            power_down <= 1'b0;
            int_enable <= 1'b0;
            @(negedge clk);
            check({wake, irq}, 2'b00, "masked request");
            @(posedge clk);
            int_enable <= 1'b1;
            wr_reg(`TIC_ADDR_CTRL, 8'h40);
            @(negedge clk);
            check(irq, 1'b0, "flag cleared");
        end
        $display("test rates done");
    endtask

    // Auto reload keeps the interval running; disable restarts the count
    task automatic test_reload();
        wr_reg(`TIC_ADDR_TARGET, 8'h02);
        wr_reg(`TIC_ADDR_CTRL, 8'h43);
        wait_irq(4 * TK);
        check(irq, 1'b1, "first timeout");
        wr_reg(`TIC_ADDR_CTRL, 8'h43);
        wait_irq(4 * TK);
        check(t <= 2 * TK, 1'b1, "reloaded timeout");
        rd_reg(`TIC_ADDR_CTRL);
        check(rd_val, 8'h07, "enable kept");
        wr_reg(`TIC_ADDR_CTRL, 8'h41);
        repeat (TK) @(posedge clk);
        wr_reg(`TIC_ADDR_CTRL, 8'h43);
        wait_irq(4 * TK);
        check(t > TK && t <= 2 * TK + 2, 1'b1, "restart from zero");
        $display("test reload done");
    endtask

    // Counts, verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        int_enable = 1'b1;
        power_down = 1'b0;
        sfr_req = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_time();
        test_rates();
        test_reload();
        finish_test();
    end

    // Hang guard, well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
